// ===== sbs_device.sv
// Sample buffer status logic of the sensor: count, flags, config and register port
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Status reads zero while buffer disabled
// - Status byte: watermark b7, overflow b6, count
// - Watermark flag set when count reaches level
// - Watermark clears once count drops below level
// - Flush empties buffer, clears watermark flag
// - Disable clears contents and watermark flag
// - Burst read of all samples empties buffer
// - Watermark routable to either interrupt pin
// - Count 0..32; push at 32 sets overflow
// - Overflow clears on sample pop (last data byte read), flush, disable
module sbs_device (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    sbs_link_if.dev          link,
    input  wire logic        sample_push_i,
    input  wire logic [47:0] sample_data_i,
    output logic             sample_pop_o,
    output logic             flush_o,
    output logic [1:0]       buffer_mode_o,
    output logic             interrupt_out_a_o,
    output logic             interrupt_out_b_o
);
    logic [1:0] mode_r,  mode_nxt;
    logic [5:0] lvl_r,   lvl_nxt;
    logic       fread_r, fread_nxt;
    logic       inten_r, inten_nxt;
    logic       route_r, route_nxt;
    logic [5:0] cnt_r,   cnt_nxt;
    logic       ovf_r,   ovf_nxt;
    logic       wmf_r,   wmf_nxt;
    logic       ack_r,   ack_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       inta_r,  inta_nxt;
    logic       intb_r,  intb_nxt;
    logic       pop_r,   pop_nxt;
    logic       flush_r, flush_nxt;

    logic       take;
    logic       wr;
    logic       rd;
    logic       flush;
    logic       disable_now;
    logic       enabled;
    logic       pop;
    logic       push;
    logic [7:0] status;
    logic [2:0] byte_idx;

    always_comb
    begin
        take        = link.req && !ack_r;
        wr          = take && link.we;
        rd          = take && !link.we;
        mode_nxt    = mode_r;
        lvl_nxt     = lvl_r;
        fread_nxt   = fread_r;
        inten_nxt   = inten_r;
        route_nxt   = route_r;
        flush       = 1'b0;
        if (wr)
        begin
            unique case (link.addr)
                sbs_pkg::REG_BUFFER_SETUP_FIRST:  mode_nxt  = link.wdata[1:0];
                sbs_pkg::REG_BUFFER_SETUP_SECOND:
                begin
                    lvl_nxt = link.wdata[5:0];
                    flush   = link.wdata[sbs_pkg::FLUSH_BIT];
                end
                sbs_pkg::REG_SENSOR_SETUP_SECOND: fread_nxt = link.wdata[sbs_pkg::FREAD_BIT];
                sbs_pkg::REG_INT_ENABLE:          inten_nxt = link.wdata[sbs_pkg::INT_EN_BIT];
                sbs_pkg::REG_INT_ROUTE:           route_nxt = link.wdata[sbs_pkg::INT_ROUTE_BIT];
                default:                          mode_nxt  = mode_r;
            endcase
        end
        disable_now = (mode_nxt == sbs_pkg::MODE_DISABLED);
        enabled     = (mode_r != sbs_pkg::MODE_DISABLED);
        // The last byte of a sample in the burst pops it; fast read skips the MSB bytes
        pop  = rd && enabled && (cnt_r != 6'h00) &&
               (link.addr == (fread_r ? sbs_pkg::REG_DATA_LAST_FAST
                                      : sbs_pkg::REG_DATA_LAST_FULL));
        push = sample_push_i && enabled;

        // Count and overflow
        cnt_nxt = cnt_r;
        ovf_nxt = ovf_r;
        if (disable_now || flush)
        begin
            cnt_nxt = 6'h00;
            ovf_nxt = 1'b0;
        end
        else
        begin
            if (pop)
            begin
                ovf_nxt = 1'b0;
            end
            if (push && !pop && cnt_r == sbs_pkg::COUNT_MAX)
            begin
                ovf_nxt = 1'b1;
            end
            else if (push && !pop)
            begin
                cnt_nxt = cnt_r + 6'h01;
            end
            else if (pop && !push)
            begin
                cnt_nxt = cnt_r - 6'h01;
            end
        end
        wmf_nxt = !disable_now && !flush && (cnt_nxt >= lvl_nxt);

        status = enabled ? {wmf_r, ovf_r, cnt_r} : sbs_pkg::RESET_BYTE;
        byte_idx = 3'(link.addr - sbs_pkg::REG_DATA_FIRST);
        rdata_nxt = rdata_r;
        if (rd)
        begin
            if (link.addr == sbs_pkg::REG_SAMPLE_BUFFER_STATUS)
                rdata_nxt = status;
            else if (link.addr >= sbs_pkg::REG_DATA_FIRST &&
                     link.addr <= sbs_pkg::REG_DATA_LAST_FULL)
                rdata_nxt = sample_data_i[8*byte_idx +: 8];
            else if (link.addr == sbs_pkg::REG_BUFFER_SETUP_FIRST)
                rdata_nxt = {6'h00, mode_r};
            else if (link.addr == sbs_pkg::REG_BUFFER_SETUP_SECOND)
                rdata_nxt = {2'h0, lvl_r};
            else if (link.addr == sbs_pkg::REG_SENSOR_SETUP_SECOND)
                rdata_nxt = {7'h00, fread_r};
            else if (link.addr == sbs_pkg::REG_INT_ENABLE)
                rdata_nxt = {7'h00, inten_r};
            else if (link.addr == sbs_pkg::REG_INT_ROUTE)
                rdata_nxt = {7'h00, route_r};
            else
                rdata_nxt = sbs_pkg::RESET_BYTE;
        end
        ack_nxt   = take;
        inta_nxt  = inten_r && !route_r && wmf_r;
        intb_nxt  = inten_r && route_r && wmf_r;
        pop_nxt   = pop;
        flush_nxt = flush || (wr && disable_now && enabled);
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            mode_r  <= sbs_pkg::MODE_DISABLED;
            lvl_r   <= 6'h00;
            fread_r <= 1'b0;
            inten_r <= 1'b0;
            route_r <= 1'b0;
            cnt_r   <= 6'h00;
            ovf_r   <= 1'b0;
            wmf_r   <= 1'b0;
            ack_r   <= 1'b0;
            rdata_r <= sbs_pkg::RESET_BYTE;
            inta_r  <= 1'b0;
            intb_r  <= 1'b0;
            pop_r   <= 1'b0;
            flush_r <= 1'b0;
        end
        else if (ce_i)
        begin
            mode_r  <= mode_nxt;
            lvl_r   <= lvl_nxt;
            fread_r <= fread_nxt;
            inten_r <= inten_nxt;
            route_r <= route_nxt;
            cnt_r   <= cnt_nxt;
            ovf_r   <= ovf_nxt;
            wmf_r   <= wmf_nxt;
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            inta_r  <= inta_nxt;
            intb_r  <= intb_nxt;
            pop_r   <= pop_nxt;
            flush_r <= flush_nxt;
        end
    end

    assign link.ack          = ack_r;
    assign link.rdata        = rdata_r;
    assign link.int_a        = inta_r;
    assign link.int_b        = intb_r;
    assign interrupt_out_a_o = inta_r;
    assign interrupt_out_b_o = intb_r;
    assign sample_pop_o      = pop_r;
    assign flush_o           = flush_r;
    assign buffer_mode_o     = mode_r;
endmodule : sbs_device
`default_nettype wire

// ===== sbs_pkg.sv
// Shared constants for the sample buffer status block and its host end
package sbs_pkg;
    // Device register offsets
    localparam logic [7:0] REG_SAMPLE_BUFFER_STATUS = 8'h0B;
    localparam logic [7:0] REG_DATA_FIRST           = 8'h0C;
    localparam logic [7:0] REG_DATA_LAST_FULL       = 8'h11;
    localparam logic [7:0] REG_DATA_LAST_FAST       = 8'h10;
    localparam logic [7:0] REG_SENSOR_SETUP_SECOND  = 8'h15;
    localparam logic [7:0] REG_BUFFER_SETUP_FIRST   = 8'h17;
    localparam logic [7:0] REG_BUFFER_SETUP_SECOND  = 8'h18;
    localparam logic [7:0] REG_INT_ENABLE           = 8'h20;
    localparam logic [7:0] REG_INT_ROUTE            = 8'h21;
    // Field positions
    localparam int STAT_WMRK_BIT  = 7;
    localparam int STAT_OVF_BIT   = 6;
    localparam int FLUSH_BIT      = 7;
    localparam int FREAD_BIT      = 0;
    localparam int INT_EN_BIT     = 0;
    localparam int INT_ROUTE_BIT  = 0;
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [5:0] COUNT_MAX     = 6'h20;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    // Host Wishbone map (byte addresses)
    localparam logic [3:0] WB_CMD    = 4'h0;
    localparam logic [3:0] WB_STATUS = 4'h4;
    localparam int CMD_ADDR_LSB  = 0;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WE_BIT    = 16;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_INTA_BIT   = 1;
    localparam int ST_INTB_BIT   = 2;
    localparam int ST_RDATA_LSB  = 8;
endpackage : sbs_pkg

// ===== sbs_link_if.sv
// Register link between the host end and the sample buffer status device
`timescale 1ns/1ps
`default_nettype none
interface sbs_link_if;
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    logic       int_a;
    logic       int_b;
    modport dev  (input req, we, addr, wdata, output ack, rdata, int_a, int_b);
    modport host (output req, we, addr, wdata, input ack, rdata, int_a, int_b);
endinterface : sbs_link_if
`default_nettype wire

// ===== sbs_host.sv
// Host end: Wishbone command registers driving single accesses on the register link
`timescale 1ns/1ps
`default_nettype none
module sbs_host (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    sbs_link_if.host         link
);
    typedef enum logic [0:0] {SBS_IDLE = 1'b0, SBS_REQ = 1'b1} sbs_state_t;

    sbs_state_t  st_r,    st_nxt;
    logic        we_r,    we_nxt;
    logic [7:0]  addr_r,  addr_nxt;
    logic [7:0]  wdata_r, wdata_nxt;
    logic [7:0]  rd_r,    rd_nxt;
    logic        ack_r,   ack_nxt;
    logic [31:0] dat_r,   dat_nxt;
    logic        acc;

    always_comb
    begin
        acc       = wb_cyc_i && wb_stb_i && !ack_r;
        st_nxt    = st_r;
        we_nxt    = we_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        rd_nxt    = rd_r;
        dat_nxt   = dat_r;
        ack_nxt   = acc;
        unique case (st_r)
            SBS_IDLE:
            begin
                // A command write while idle launches one link access; while busy it is ignored
                if (acc && wb_we_i && wb_adr_i == sbs_pkg::WB_CMD)
                begin
                    if (wb_sel_i[0])
                        addr_nxt = wb_dat_i[sbs_pkg::CMD_ADDR_LSB +: 8];
                    if (wb_sel_i[1])
                        wdata_nxt = wb_dat_i[sbs_pkg::CMD_WDATA_LSB +: 8];
                    if (wb_sel_i[2])
                        we_nxt = wb_dat_i[sbs_pkg::CMD_WE_BIT];
                    st_nxt = SBS_REQ;
                end
            end
            SBS_REQ:
            begin
                if (link.ack)
                begin
                    if (!we_r)
                        rd_nxt = link.rdata;
                    st_nxt = SBS_IDLE;
                end
            end
        endcase
        if (acc && !wb_we_i)
        begin
            dat_nxt = 32'h0000_0000;
            if (wb_adr_i == sbs_pkg::WB_STATUS)
            begin
                dat_nxt[sbs_pkg::ST_BUSY_BIT]      = (st_r == SBS_REQ);
                dat_nxt[sbs_pkg::ST_INTA_BIT]      = link.int_a;
                dat_nxt[sbs_pkg::ST_INTB_BIT]      = link.int_b;
                dat_nxt[sbs_pkg::ST_RDATA_LSB +: 8] = rd_r;
            end
            else if (wb_adr_i == sbs_pkg::WB_CMD)
                dat_nxt = {15'h0000, we_r, wdata_r, addr_r};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            st_r    <= SBS_IDLE;
            we_r    <= 1'b0;
            addr_r  <= 8'h00;
            wdata_r <= 8'h00;
            rd_r    <= 8'h00;
            ack_r   <= 1'b0;
            dat_r   <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            st_r    <= st_nxt;
            we_r    <= we_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            rd_r    <= rd_nxt;
            ack_r   <= ack_nxt;
            dat_r   <= dat_nxt;
        end
    end

    assign link.req   = (st_r == SBS_REQ);
    assign link.we    = we_r;
    assign link.addr  = addr_r;
    assign link.wdata = wdata_r;
    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = dat_r;
endmodule : sbs_host
`default_nettype wire

// ===== sbs_assertions.sv
// Link protocol and status byte checks between host end and device
`timescale 1ns/1ps
`default_nettype none
module sbs_assertions (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       req,
    input wire logic       we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata,
    input wire logic       int_a,
    input wire logic       int_b
);
    logic [1:0] mode_r;
    logic [5:0] level_r;
    logic       st_rd;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Shadow of mode and level as written over the link
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            mode_r  <= 2'h0;
            level_r <= 6'h00;
        end
        else if (req && we && !ack && addr == sbs_pkg::REG_BUFFER_SETUP_FIRST)
            mode_r <= wdata[1:0];
        else if (req && we && !ack && addr == sbs_pkg::REG_BUFFER_SETUP_SECOND)
            level_r <= wdata[5:0];
    end
    assign st_rd = ack && !we && addr == sbs_pkg::REG_SAMPLE_BUFFER_STATUS;
    a_ack_next: assert property (req && !ack |=> ack)
        else $error("no answer one cycle after request");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    a_req_drop: assert property (ack |=> !req)
        else $error("request kept after answer");
    a_req_hold: assert property (req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before answer");
    a_off_zero: assert property (st_rd && mode_r == sbs_pkg::MODE_DISABLED |-> rdata == 8'h00)
        else $error("status not zero while disabled");
    a_count_max: assert property (st_rd |-> rdata[5:0] <= sbs_pkg::COUNT_MAX)
        else $error("count above full");
    a_wmrk_level: assert property (st_rd && mode_r != sbs_pkg::MODE_DISABLED |->
                                   rdata[7] == (rdata[5:0] >= level_r))
        else $error("watermark flag disagrees with count");
    a_ovf_full: assert property (st_rd && rdata[6] |-> rdata[5:0] == sbs_pkg::COUNT_MAX)
        else $error("overflow without full count");
    a_pins_apart: assert property (!(int_a && int_b))
        else $error("both interrupt pins high");
endmodule : sbs_assertions
`default_nettype wire

// ===== tb_sample_buffer_status.sv
// Self-checking bench: host end and device joined over the register link
`timescale 1ns/1ps
`default_nettype none
module tb_sample_buffer_status;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        wwe = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_q;
    logic        wb_ack;
    logic        push = 1'b0;
    logic [47:0] sdata = 48'h0;
    logic [1:0]  mode_o;
    logic [31:0] rsp;
    logic [7:0]  rd;
    int          fail_count = 0;
    int          tests_run = 0;
    int          seed = 32'hC762;
    int          cycles = 0;
    int          qd[$];
    int          ovf = 0;
    int          level = 0;
    int          mode = 0;
    int          fast = 0;
    int          npop = 0;
    int          nflush = 0;
    int          pops = 0;
    int          flushes = 0;
    logic        pop_w;
    logic        flush_w;
    logic        inta_w;
    logic        intb_w;
    sbs_link_if link_if ();
    sbs_host u_sbs_host (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .link(link_if));
    sbs_device u_sbs_device (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .link(link_if),
        .sample_push_i(push), .sample_data_i(sdata), .sample_pop_o(pop_w), .flush_o(flush_w),
        .buffer_mode_o(mode_o), .interrupt_out_a_o(inta_w), .interrupt_out_b_o(intb_w));
    sbs_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .req(link_if.req),
        .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
        .rdata(link_if.rdata), .int_a(link_if.int_a), .int_b(link_if.int_b));
    always #12.5 clk_i = ~clk_i;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clk_i)
    begin
        cycles++;
        // Pulses stand one cycle, so each is counted once
        if (pop_w === 1'b1)
            pops++;
        if (flush_w === 1'b1)
            flushes++;
        if (cycles == 50000)
        begin
            fail_count++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= w;
        adr <= a;
        dat <= d;
        do
            @(posedge clk_i);
        while (wb_ack !== 1'b1);
        rsp = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // One device access: launch the command, then poll until idle
    task automatic link(input logic w, input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, 4'h0, {15'h0, w, d, a});
        do
            wb(1'b0, 4'h4, 32'h0);
        while (rsp[0] !== 1'b0);
        rd = rsp[15:8];
    endtask : link
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        link(1'b1, a, d);
        if (a == 8'h15)
            fast = d[0];
        if (a == 8'h18)
            level = d[5:0];
        if ((a == 8'h18 && d[7]) || (a == 8'h17 && d[1:0] == 2'h0 && mode != 0))
            nflush++;
        if ((a == 8'h17 && d[1:0] == 2'h0) || (a == 8'h18 && d[7]))
        begin
            qd.delete();
            ovf = 0;
        end
        if (a == 8'h17)
            mode = d[1:0];
    endtask : wr
    task automatic st_chk();
        link(1'b0, 8'h0B, 8'h00);
        chk("status", rd, (mode == 0) ? 8'h00 :
            {qd.size() >= level, ovf != 0, 6'(qd.size())});
    endtask : st_chk
    task automatic push_n(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            push <= 1'b1;
            sdata <= {16'($random(seed)), 32'($random(seed))};
            @(posedge clk_i);
            push <= 1'b0;
            if (mode != 0 && qd.size() == 32)
                ovf = 1;
            else if (mode != 0)
                qd.push_back(1);
        end
    endtask : push_n
    task automatic burst();
        st_chk();
        while (qd.size() > 0)
        begin
            for (int a = 12; a <= (fast != 0 ? 16 : 17); a += fast + 1)
            begin
                link(1'b0, 8'(a), 8'h00);
                chk("sample byte", rd, sdata[8*(a-12) +: 8]);
            end
            void'(qd.pop_front());
            npop++;
            ovf = 0;
            st_chk();
        end
    endtask : burst
    initial
    begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        st_chk();
        wb(1'b0, 4'h0, 32'h0);
        chk("command", rsp[7:0], 8'h0B);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped", rsp[7:0], 8'h00);
        wr(8'h18, 8'h05);
        for (int m = 1; m < 4; m++)
        begin
            wr(8'h17, 8'(m));
            chk("mode", {6'h0, mode_o}, 8'(m));
        end
        wr(8'h0B, 8'hFF);
        for (int i = 0; i < 34; i++)
        begin
            push_n(1);
            st_chk();
        end
        $display("fill test done");
        burst();
        wr(8'h15, 8'h01);
        push_n(3);
        burst();
        wr(8'h15, 8'h00);
        $display("burst test done");
        push_n(33);
        wr(8'h18, 8'h85);
        st_chk();
        push_n(33);
        wr(8'h17, 8'h00);
        push_n(2);
        st_chk();
        wr(8'h17, 8'h01);
        st_chk();
        $display("flush and disable test done");
        push_n(6);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h20, 8'(i < 2));
            wr(8'h21, 8'(i & 1));
            repeat (3) @(posedge clk_i);
            wb(1'b0, 4'h4, 32'h0);
            chk("pins", {6'h0, rsp[2:1]}, 8'(i < 2 ? i + 1 : 0));
            chk("pin outs", {6'h0, intb_w, inta_w}, 8'(i < 2 ? i + 1 : 0));
        end
        $display("interrupt test done");
        chk("pop pulses", 8'(pops), 8'(npop));
        chk("flush pulses", 8'(flushes), 8'(nflush));
        // Mid-run reset: mode, status byte and interrupt pins must return to zero
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        mode = 0;
        level = 0;
        fast = 0;
        ovf = 0;
        qd.delete();
        chk("mode after reset", {6'h0, mode_o}, 8'h00);
        st_chk();
        wb(1'b0, 4'h4, 32'h0);
        chk("pins after reset", {6'h0, rsp[2:1]}, 8'h00);
        $display("reset test done");
        complete_run();
    end
endmodule : tb_sample_buffer_status
`default_nettype wire
